// >>> pkg/scr_pkg.sv
/*
 * Package for the synthesizer configuration register bank: control codes,
 * field positions, reset values and the decoded configuration structs.
 * Assumes 32-bit serial words, control code in the three lowest bits.
 */
`default_nettype none

package scr_pkg;

    localparam int WORD_W = 32;

    // Control codes in bits 2:0 of every word
    localparam logic [2:0] CODE_MAIN = 3'h0;
    localparam logic [2:0] CODE_REFCP = 3'h2;
    localparam logic [2:0] CODE_CLKDIV = 3'h3;
    localparam logic [2:0] CODE_OUTSTG = 3'h4;
    localparam logic [2:0] CODE_LOCKPIN = 3'h5;
    localparam int CODE_LSB = 0;
    localparam int CODE_MSB = 2;

    // Charge pump and reference word: double buffer enable
    localparam int REFCP_DBUF_BIT = 13;

    // Clock divider word
    localparam int CD_FAST_BANDSEL_BIT = 23;
    localparam int CD_ABP_BIT = 22;
    localparam int CD_CHG_CANCEL_BIT = 21;
    localparam int CD_CSR_BIT = 18;
    localparam int CD_MODE_MSB = 16;
    localparam int CD_MODE_LSB = 15;
    localparam int CD_VALUE_MSB = 14;
    localparam int CD_VALUE_LSB = 3;

    // Output stage word
    localparam int OS_FB_DIRECT_BIT = 23;
    localparam int OS_RFDIV_MSB = 22;
    localparam int OS_RFDIV_LSB = 20;
    localparam int OS_BSDIV_MSB = 19;
    localparam int OS_BSDIV_LSB = 12;
    localparam int OS_VCO_PD_BIT = 11;
    localparam int OS_MUTE_BIT = 10;
    localparam int OS_AUX_FUND_BIT = 9;
    localparam int OS_AUX_EN_BIT = 8;
    localparam int OS_AUX_PWR_MSB = 7;
    localparam int OS_AUX_PWR_LSB = 6;
    localparam int OS_RF_EN_BIT = 5;
    localparam int OS_RF_PWR_MSB = 4;
    localparam int OS_RF_PWR_LSB = 3;

    // Lock pin word
    localparam int LP_MODE_MSB = 23;
    localparam int LP_MODE_LSB = 22;

    typedef enum logic [1:0] {
        CDM_OFF = 2'b00,
        CDM_FAST_LOCK = 2'b01,
        CDM_RESYNC = 2'b10,
        CDM_RSVD = 2'b11
    } scr_cdmode_e;

    typedef struct packed {
        logic fast_bandsel;
        logic antibacklash_width_sel;
        logic charge_cancel;
        logic cycle_slip_reduction;
        scr_cdmode_e clkdiv_mode;
        logic [11:0] clkdiv_value;
    } scr_clkdiv_s;

    typedef struct packed {
        logic fb_direct;
        logic [2:0] rf_div_sel;
        logic [7:0] bandsel_div;
        logic vco_pd;
        logic mute_until_locked;
        logic aux_fundamental;
        logic aux_en;
        logic [1:0] aux_pwr;
        logic rf_en;
        logic [1:0] rf_pwr;
    } scr_outstg_s;

    localparam scr_clkdiv_s CLKDIV_RST = '0;
    localparam scr_outstg_s OUTSTG_RST = '0;
    localparam logic [1:0] LOCKPIN_RST = 2'h0;
    localparam logic [2:0] RFDIV_RST = 3'h0;
    localparam logic [WORD_W-1:0] SHIFT_RST = 32'h0000_0000;

endpackage : scr_pkg

`default_nettype wire

// >>> hdl/scr_config_regs.sv
/*
 * Configuration register bank for words with control codes 011, 100, 101.
 * Three-wire serial port (clock, data, load enable) is sampled on CLK_SYS.
 * Assumes CLK_SYS is much faster than the serial clock; lock detect and
 * clock enable come from logic on CLK_SYS.
 */
// Behaviour
// - Codes 011, 100, 101 route word to clock-divider, output-stage, lock-pin
// - Clock-divider bit 23 selects faster band selection sequence
// - Clock-divider bit 22 selects 3 ns antibacklash pulse, else 6 ns
// - Clock-divider bit 21 enables charge pump charge cancellation
// - Clock-divider bit 18 enables cycle slip reduction
// - Mode bits 16:15: 10 resync, 01 fast lock, 00 divider off
// - Twelve-bit value at bits 14:3 is resync and fast lock timeout
// - Output-stage bit 23 feeds N counter from oscillator directly
// - Output-stage bits 22:20 select RF output divider ratio
// - RF divider select double buffered until main word when enabled
// - Bits 19:12 divide reference output for band select clock
// - Output-stage bit 11 powers the oscillator down
// - Bit 10 holds RF output supply off until lock
// - Bit 9 selects auxiliary source: divider or fundamental
// - Bit 8 enables the auxiliary output
// - Bit 5 enables the primary output
// - Bits 7:6 auxiliary power, bits 4:3 primary power
// - Lock-pin word bits 23:22 select lock indicator pin function
`timescale 1ns/1ps
`default_nettype none

module scr_config_regs (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic CE,
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic SER_LOAD,
    input wire logic LOCK_DET,
    output var scr_pkg::scr_clkdiv_s CLKDIV_CFG,
    output var scr_pkg::scr_outstg_s OUTSTG_CFG,
    output logic [2:0] RF_DIV_ACTIVE,
    output logic [1:0] LOCK_INDICATOR_PIN_MODE,
    output logic PHASE_RESYNC_EN,
    output logic FAST_LOCK_EN,
    output logic RF_SUPPLY_ON,
    output logic DBUF_EN
);
    import scr_pkg::*;

    function automatic logic [2:0] word_code(input logic [WORD_W-1:0] w);
        return w[CODE_MSB:CODE_LSB];
    endfunction

    logic [2:0] clk_sync1;
    logic [2:0] clk_sync2;
    logic clk_prev;
    logic load_prev;
    logic [WORD_W-1:0] shift;
    logic [2:0] rf_div_pending;
    logic clk_rise;
    logic latch_go;
    logic [2:0] code;
    scr_cdmode_e next_mode;

    // Pins: index 0 clock, 1 data, 2 load
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            clk_sync1 <= 3'h0;
            clk_sync2 <= 3'h0;
            clk_prev <= 1'b0;
            load_prev <= 1'b0;
        end else if (CE) begin
            clk_sync1 <= {SER_LOAD, SER_DATA, SER_CLK};
            clk_sync2 <= clk_sync1;
            clk_prev <= clk_sync2[0];
            load_prev <= clk_sync2[2];
        end
    end

    assign clk_rise = CE && clk_sync2[0] && !clk_prev;
    assign latch_go = CE && clk_sync2[2] && !load_prev;
    assign code = word_code(shift);
    assign next_mode = scr_cdmode_e'(shift[CD_MODE_MSB:CD_MODE_LSB]);

    // Serial word, most significant bit first
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            shift <= SHIFT_RST;
        end else if (clk_rise) begin
            shift <= {shift[WORD_W-2:0], clk_sync2[1]};
        end
    end

    // Clock-divider word
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CLKDIV_CFG <= CLKDIV_RST;
            PHASE_RESYNC_EN <= 1'b0;
            FAST_LOCK_EN <= 1'b0;
        end else if (latch_go && code == CODE_CLKDIV) begin
            CLKDIV_CFG.fast_bandsel <= shift[CD_FAST_BANDSEL_BIT];
            CLKDIV_CFG.antibacklash_width_sel <= shift[CD_ABP_BIT];
            CLKDIV_CFG.charge_cancel <= shift[CD_CHG_CANCEL_BIT];
            CLKDIV_CFG.cycle_slip_reduction <= shift[CD_CSR_BIT];
            CLKDIV_CFG.clkdiv_mode <= next_mode;
            CLKDIV_CFG.clkdiv_value <= shift[CD_VALUE_MSB:CD_VALUE_LSB];
            PHASE_RESYNC_EN <= (next_mode == CDM_RESYNC);
            FAST_LOCK_EN <= (next_mode == CDM_FAST_LOCK);
        end
    end

    // Output-stage word
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            OUTSTG_CFG <= OUTSTG_RST;
        end else if (latch_go && code == CODE_OUTSTG) begin
            OUTSTG_CFG.fb_direct <= shift[OS_FB_DIRECT_BIT];
            OUTSTG_CFG.rf_div_sel <= shift[OS_RFDIV_MSB:OS_RFDIV_LSB];
            OUTSTG_CFG.bandsel_div <= shift[OS_BSDIV_MSB:OS_BSDIV_LSB];
            OUTSTG_CFG.vco_pd <= shift[OS_VCO_PD_BIT];
            OUTSTG_CFG.mute_until_locked <= shift[OS_MUTE_BIT];
            OUTSTG_CFG.aux_fundamental <= shift[OS_AUX_FUND_BIT];
            OUTSTG_CFG.aux_en <= shift[OS_AUX_EN_BIT];
            OUTSTG_CFG.aux_pwr <= shift[OS_AUX_PWR_MSB:OS_AUX_PWR_LSB];
            OUTSTG_CFG.rf_en <= shift[OS_RF_EN_BIT];
            OUTSTG_CFG.rf_pwr <= shift[OS_RF_PWR_MSB:OS_RF_PWR_LSB];
        end
    end

    // Lock-pin word
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            LOCK_INDICATOR_PIN_MODE <= LOCKPIN_RST;
        end else if (latch_go && code == CODE_LOCKPIN) begin
            LOCK_INDICATOR_PIN_MODE <= shift[LP_MODE_MSB:LP_MODE_LSB];
        end
    end

    // Double buffer enable snooped from the reference word
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            DBUF_EN <= 1'b0;
        end else if (latch_go && code == CODE_REFCP) begin
            DBUF_EN <= shift[REFCP_DBUF_BIT];
        end
    end

    // RF divider: pending copy, applied now or on next main word
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rf_div_pending <= RFDIV_RST;
            RF_DIV_ACTIVE <= RFDIV_RST;
        end else if (latch_go) begin
            if (code == CODE_OUTSTG) begin
                rf_div_pending <= shift[OS_RFDIV_MSB:OS_RFDIV_LSB];
                if (!DBUF_EN) begin
                    RF_DIV_ACTIVE <= shift[OS_RFDIV_MSB:OS_RFDIV_LSB];
                end
            end else if (code == CODE_MAIN) begin
                RF_DIV_ACTIVE <= rf_div_pending;
            end
        end
    end

    // Output stage supply gated by lock when muting is requested
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            RF_SUPPLY_ON <= 1'b0;
        end else if (CE) begin
            RF_SUPPLY_ON <= !OUTSTG_CFG.mute_until_locked || LOCK_DET;
        end
    end

    chk_route_clkdiv_word: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            CLKDIV_CFG.clkdiv_value == $past(shift[CD_VALUE_MSB:CD_VALUE_LSB])
            && CLKDIV_CFG.fast_bandsel == $past(shift[CD_FAST_BANDSEL_BIT]))
        else $error("clock divider word not stored");

    chk_other_words_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            $stable(OUTSTG_CFG) && $stable(LOCK_INDICATOR_PIN_MODE))
        else $error("unrelated word changed");

    chk_mode_decode_resync: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        PHASE_RESYNC_EN == (CLKDIV_CFG.clkdiv_mode == CDM_RESYNC)
        && FAST_LOCK_EN == (CLKDIV_CFG.clkdiv_mode == CDM_FAST_LOCK))
        else $error("clock divider mode decode wrong");

    chk_mute_until_lock: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        CE && OUTSTG_CFG.mute_until_locked && !LOCK_DET |=> !RF_SUPPLY_ON)
        else $error("output supply on before lock");

    chk_rfdiv_buffered_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG && DBUF_EN |=> $stable(RF_DIV_ACTIVE))
        else $error("buffered divider applied early");

    chk_rfdiv_direct_apply: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG && !DBUF_EN |=>
            RF_DIV_ACTIVE == $past(shift[OS_RFDIV_MSB:OS_RFDIV_LSB]))
        else $error("divider select not applied");

    chk_rfdiv_main_apply: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_MAIN |=> RF_DIV_ACTIVE == $past(rf_div_pending))
        else $error("main word did not apply divider");

    chk_lock_pin_mode: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_LOCKPIN |=>
            LOCK_INDICATOR_PIN_MODE == $past(shift[LP_MODE_MSB:LP_MODE_LSB]))
        else $error("lock pin mode not stored");

    chk_output_stage_bits: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.aux_en == $past(shift[OS_AUX_EN_BIT])
            && OUTSTG_CFG.rf_en == $past(shift[OS_RF_EN_BIT]))
        else $error("output enables not stored");

    chk_clkdiv_abp_bit: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            CLKDIV_CFG.antibacklash_width_sel == $past(shift[CD_ABP_BIT]))
        else $error("antibacklash select not stored");

    chk_clkdiv_chg_cancel: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            CLKDIV_CFG.charge_cancel == $past(shift[CD_CHG_CANCEL_BIT]))
        else $error("charge cancel bit not stored");

    chk_clkdiv_csr_bit: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            CLKDIV_CFG.cycle_slip_reduction == $past(shift[CD_CSR_BIT]))
        else $error("cycle slip bit not stored");

    chk_clkdiv_mode_field: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV |=>
            CLKDIV_CFG.clkdiv_mode == $past(shift[CD_MODE_MSB:CD_MODE_LSB]))
        else $error("clock divider mode not stored");

    chk_resync_mode_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV
            && shift[CD_MODE_MSB:CD_MODE_LSB] == 2'b10 |=>
            PHASE_RESYNC_EN && !FAST_LOCK_EN)
        else $error("resync mode not enabled");

    chk_fast_lock_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_CLKDIV
            && shift[CD_MODE_MSB:CD_MODE_LSB] == 2'b01 |=>
            FAST_LOCK_EN && !PHASE_RESYNC_EN)
        else $error("fast lock mode not enabled");

    chk_feedback_select: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.fb_direct == $past(shift[OS_FB_DIRECT_BIT]))
        else $error("feedback select not stored");

    chk_bandsel_divider: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.bandsel_div == $past(shift[OS_BSDIV_MSB:OS_BSDIV_LSB]))
        else $error("band select divider not stored");

    chk_vco_powerdown: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.vco_pd == $past(shift[OS_VCO_PD_BIT]))
        else $error("oscillator power down not stored");

    chk_aux_source_sel: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.aux_fundamental == $past(shift[OS_AUX_FUND_BIT]))
        else $error("auxiliary source not stored");

    chk_output_power_fields: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            OUTSTG_CFG.aux_pwr == $past(shift[OS_AUX_PWR_MSB:OS_AUX_PWR_LSB])
            && OUTSTG_CFG.rf_pwr == $past(shift[OS_RF_PWR_MSB:OS_RF_PWR_LSB]))
        else $error("output power fields not stored");

    chk_outstg_write_isolated: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            $stable(CLKDIV_CFG) && $stable(LOCK_INDICATOR_PIN_MODE))
        else $error("output stage write changed other word");

    chk_lockpin_write_isolated: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_LOCKPIN |=>
            $stable(CLKDIV_CFG) && $stable(OUTSTG_CFG))
        else $error("lock pin write changed other word");

    chk_refused_code_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && (code == 3'h1 || code > CODE_LOCKPIN) |=>
            $stable(CLKDIV_CFG) && $stable(OUTSTG_CFG)
            && $stable(LOCK_INDICATOR_PIN_MODE) && $stable(RF_DIV_ACTIVE))
        else $error("unused code changed a word");

    chk_supply_on_unmuted: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        CE && !OUTSTG_CFG.mute_until_locked |=> RF_SUPPLY_ON)
        else $error("output supply off without muting");

    chk_rfdiv_pending_capture: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_OUTSTG |=>
            rf_div_pending == $past(shift[OS_RFDIV_MSB:OS_RFDIV_LSB]))
        else $error("pending divider not captured");

    chk_dbuf_capture: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        latch_go && code == CODE_REFCP |=>
            DBUF_EN == $past(shift[REFCP_DBUF_BIT]))
        else $error("double buffer enable not captured");

endmodule // scr_config_regs

`default_nettype wire

// >>> sim/scr_host_model.sv
/* Host model: shifts 32-bit words MSB first into the three-wire port.
   Assumes start is pulsed only while busy is low. */
`timescale 1ns/1ps
`default_nettype none

module scr_host_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic slow,
    input wire logic [31:0] word,
    output logic busy,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_load
);
    logic [4:0] cnt;
    logic [4:0] hp;
    logic [5:0] idx;
    logic [31:0] sr;

    assign hp = slow ? 5'h8 : 5'h4;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {busy, ser_clk, ser_data, ser_load, cnt, idx, sr} <= '0;
        end else if (!busy) begin
            ser_data <= ~ser_data; // Released line keeps moving
            if (start) begin
                busy <= 1'b1;
                sr <= word;
                {cnt, idx} <= '0;
            end
        end else begin
            cnt <= cnt + 5'h1;
            if (idx < 6'd32) begin
                if (cnt == 5'h0) ser_data <= sr[31];
                if (cnt == hp) ser_clk <= 1'b1;
            end else begin
                ser_data <= ~ser_data;
                if (cnt == hp) ser_load <= 1'b1; // Clock is low here
            end
            if (cnt == {hp[3:0], 1'b0} - 5'h1) begin
                cnt <= 5'h0;
                ser_clk <= 1'b0;
                ser_load <= 1'b0;
                idx <= idx + 6'h1;
                sr <= {sr[30:0], 1'b0};
                if (idx == 6'd32) busy <= 1'b0;
            end
        end
    end
endmodule // scr_host_model

`default_nettype wire

// >>> sim/scr_config_regs_tb_top.sv
/* Bench: host model writes words, a monitor compares all outputs after
   each load against notes queued by the writer. Assumes scr_pkg. */
`timescale 1ns/1ps
`default_nettype none

module scr_config_regs_tb_top;
    import scr_pkg::*;

    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic lock_det = 1'b0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [31:0] word = '0;
    logic busy, ser_clk, ser_data, ser_load, resync, fast, sup_on, dbuf;
    scr_clkdiv_s cd;
    scr_clkdiv_s e_cd = '0;
    scr_outstg_s os;
    scr_outstg_s e_os = '0;
    logic [2:0] act;
    logic [2:0] e_act = '0;
    logic [2:0] e_pend = '0;
    logic [1:0] lpm;
    logic [1:0] e_lp = '0;
    logic e_dbuf = 1'b0;
    logic [47:0] notes[$];
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    initial forever #5 clk_sys = ~clk_sys;

    scr_host_model i_host (.clk(clk_sys), .arst_n(arst_n), .start(start), .slow(slow),
        .word(word), .busy(busy), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));

    scr_config_regs i_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .CE(ce), .SER_CLK(ser_clk),
        .SER_DATA(ser_data), .SER_LOAD(ser_load), .LOCK_DET(lock_det), .CLKDIV_CFG(cd),
        .OUTSTG_CFG(os), .RF_DIV_ACTIVE(act), .LOCK_INDICATOR_PIN_MODE(lpm),
        .PHASE_RESYNC_EN(resync), .FAST_LOCK_EN(fast), .RF_SUPPLY_ON(sup_on), .DBUF_EN(dbuf));

    task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Paused device keeps its state when hold is set
    task automatic send(input logic [31:0] w, input logic hold);
        if (!hold) begin
            case (w[2:0])
                CODE_CLKDIV: e_cd = {w[23:21], w[18], w[16:3]};
                CODE_OUTSTG: begin
                    e_os = w[23:3];
                    e_pend = w[22:20];
                    if (!e_dbuf) e_act = w[22:20];
                end
                CODE_LOCKPIN: e_lp = w[23:22];
                CODE_REFCP: e_dbuf = w[REFCP_DBUF_BIT];
                CODE_MAIN: e_act = e_pend;
                default: ;
            endcase
        end
        notes.push_back({e_cd, e_os, e_act, e_lp, e_cd.clkdiv_mode == CDM_RESYNC,
            e_cd.clkdiv_mode == CDM_FAST_LOCK, !e_os.mute_until_locked || lock_det, e_dbuf});
        start <= 1'b1;
        word <= w;
        @(posedge clk_sys);
        start <= 1'b0;
        do @(posedge clk_sys); while (busy);
    endtask

    initial begin : monitor
        logic [47:0] n;
        forever begin
            @(posedge ser_load);
            repeat (5) @(posedge clk_sys);
            #1;
            n = notes.pop_front();
            check("clkdiv_cfg", 21'(n[47:30]), 21'(cd));
            check("outstg_cfg", n[29:9], os);
            check("rf_div_active", 21'(n[8:6]), 21'(act));
            check("lock_pin_mode", 21'(n[5:4]), 21'(lpm));
            check("divider_mode", 21'(n[3:2]), 21'({resync, fast}));
            check("rf_supply_on", 21'(n[1]), 21'(sup_on));
            check("dbuf_en", 21'(n[0]), 21'(dbuf));
        end
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin : main
        logic [31:0] w;
        void'($urandom(32'h7048));
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        send(32'h5, 0);
        send(32'h4, 0);
        send(32'h3, 0);
        send(32'h4002, 0);
        send(32'h11, 0);
        send(32'h0, 0);
        for (int m = 0; m < 4; m++) begin
            w = $urandom;
            send({w[31:17], 2'(m), w[14:3], CODE_CLKDIV}, 0);
        end
        for (int i = 0; i < 15; i++) begin
            // Keep lock steady until last supply check
            @(posedge clk_sys);
            w = $urandom;
            w[19] = 1'b0;
            slow <= w[31];
            lock_det <= w[30];
            @(posedge clk_sys);
            send({w[31:3], 3'(3 + i % 3)}, 0);
        end
        for (int k = 0; k < 3; k++) begin
            w = $urandom;
            send({w[31:3], k == 0 ? 3'h1 : 3'(k + 5)}, 0);
        end
        send(32'h6002, 0);
        w = $urandom;
        send({w[31:23], ~e_act, 1'b0, w[18:3], CODE_OUTSTG}, 0);
        send(32'h0, 0);
        ce <= 1'b0;
        w = $urandom;
        send({w[31:24], ~e_lp, w[21:3], CODE_LOCKPIN}, 1);
        ce <= 1'b1;
        @(posedge clk_sys);
        send({w[31:24], ~e_lp, w[21:3], CODE_LOCKPIN}, 0);
        repeat (10) @(posedge clk_sys);
        give_verdict();
    end
endmodule // scr_config_regs_tb_top

`default_nettype wire
